// ---- hdl/dfc_top.sv ----
// Serial configuration port and decimation filter control decode
`timescale 1ns/1ps
`default_nettype none

module dfc_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Configuration pins
    input wire logic reset_pin_i,
    input wire logic serial_clock_pin_i,
    input wire logic serial_data_in_pin_i,
    input wire logic serial_enable_or_format_pin_i,
    input wire logic power_mux_control_a_i,
    input wire logic power_mux_control_b_i,
    // Processing path controls
    output logic use_custom_coeff_o,
    output logic offset_corr_en_o,
    output logic decim_en_o,
    output logic [2:0] decim_rate_o,
    output logic odd_tap_o,
    output dfc_pkg::dfc_filter_type filter_mode_o,
    // Analog and output interface controls
    output logic parallel_mode_o,
    output logic coarse_gain_o,
    output logic ext_ref_o,
    output logic lvds_sel_o,
    output logic twos_comp_o,
    output logic [1:0] power_mode_o,
    output logic mux_mode_o
);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [5:0] pins_s;
    logic rst_pin_s;
    logic sclk_s;
    logic serial_data_in_pin_s;
    logic sen_s;
    logic [1:0] ctrl_s;

    dfc_sync #(.WIDTH(6)) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i({reset_pin_i, serial_clock_pin_i, serial_data_in_pin_i,
              serial_enable_or_format_pin_i, power_mux_control_a_i,
              power_mux_control_b_i}),
        .q_o(pins_s)
    );

    assign rst_pin_s = pins_s[5];
    assign sclk_s = pins_s[4];
    assign serial_data_in_pin_s = pins_s[3];
    assign sen_s = pins_s[2];
    assign ctrl_s = pins_s[1:0];

    // ------------------------------------------------------------
    // Serial receiver
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_WAIT = 3'b100
    } dfc_rx_state_type;

    dfc_rx_state_type state, next_state;
    logic [dfc_pkg::FRAME_BITS-1:0] shreg, next_shreg;
    logic [3:0] cnt, next_cnt;
    logic sclk_prev, next_sclk_prev;
    logic sclk_fall;
    logic wr_now;
    logic [15:0] frame_word;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;

    assign sclk_fall = sclk_prev & ~sclk_s;
    assign frame_word = {shreg[dfc_pkg::FRAME_BITS-2:0], serial_data_in_pin_s};
    assign wr_addr = frame_word[15:8];
    assign wr_data = frame_word[7:0];

    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_cnt = cnt;
        next_sclk_prev = sclk_s;
        wr_now = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (!rst_pin_s && !sen_s) begin
                    next_state = ST_SHIFT;
                    next_cnt = 4'h0;
                end
            end
            ST_SHIFT: begin
                // Enable rising mid-frame drops the partial word
                if (sen_s || rst_pin_s) begin
                    next_state = ST_IDLE;
                end else if (sclk_fall) begin
                    next_shreg = frame_word;
                    next_cnt = cnt + 4'h1;
                    if (cnt == dfc_pkg::LAST_BIT_IDX) begin
                        wr_now = 1'b1;
                        next_state = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (sen_s || rst_pin_s) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= ST_IDLE;
            shreg <= '0;
            cnt <= 4'h0;
            sclk_prev <= 1'b0;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            cnt <= next_cnt;
            sclk_prev <= next_sclk_prev;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] proc_ctrl, next_proc_ctrl;
    logic [1:0] band_sel, next_band_sel;

    always_comb begin
        next_proc_ctrl = proc_ctrl;
        next_band_sel = band_sel;
        // Pin held high also keeps the map cleared for parallel mode
        if (rst_pin_s) begin
            next_proc_ctrl = dfc_pkg::PROC_CTRL_RESET;
            next_band_sel = dfc_pkg::BAND_SEL_RESET;
        end else if (wr_now) begin
            if (wr_addr == dfc_pkg::SW_RESET_ADDR
                && wr_data[dfc_pkg::SW_RESET_BIT]) begin
                next_proc_ctrl = dfc_pkg::PROC_CTRL_RESET;
                next_band_sel = dfc_pkg::BAND_SEL_RESET;
            end else if (wr_addr == dfc_pkg::PROC_CTRL_ADDR) begin
                next_proc_ctrl = wr_data;
            end else if (wr_addr == dfc_pkg::BAND_SEL_ADDR) begin
                // Upper six bits carry nothing and are dropped
                next_band_sel = wr_data[dfc_pkg::BAND_MSB:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            proc_ctrl <= dfc_pkg::PROC_CTRL_RESET;
            band_sel <= dfc_pkg::BAND_SEL_RESET;
        end else begin
            proc_ctrl <= next_proc_ctrl;
            band_sel <= next_band_sel;
        end
    end

    // ------------------------------------------------------------
    // Filter decode
    // ------------------------------------------------------------
    function automatic dfc_pkg::dfc_filter_type decode_filter(
        input logic custom,
        input logic dec_en,
        input logic [2:0] rate,
        input logic [1:0] band
    );
        dfc_pkg::dfc_filter_type f;
        f = dfc_pkg::FLT_NONE;
        if (custom) begin
            f = dfc_pkg::FLT_CUSTOM;
        end else if (dec_en) begin
            if (rate == dfc_pkg::RATE_DIV2) begin
                if (band == dfc_pkg::BAND_0) begin
                    f = dfc_pkg::FLT_LP_FS4;
                end else if (band == dfc_pkg::BAND_1) begin
                    f = dfc_pkg::FLT_HP_FS4;
                end
            end else if (rate == dfc_pkg::RATE_DIV4) begin
                if (band == dfc_pkg::BAND_0) begin
                    f = dfc_pkg::FLT_LP_FS8;
                end else if (band == dfc_pkg::BAND_1) begin
                    f = dfc_pkg::FLT_BP_3FS16;
                end else if (band == dfc_pkg::BAND_2) begin
                    f = dfc_pkg::FLT_BP_5FS16;
                end else begin
                    f = dfc_pkg::FLT_HP_3FS8;
                end
            end
            // Rates that need user coefficients have no built-in response
        end
        return f;
    endfunction

    logic ctl_offset;
    logic ctl_custom;
    logic ctl_dec_en;
    logic [2:0] ctl_rate;

    assign ctl_offset = proc_ctrl[dfc_pkg::OFFSET_EN_BIT];
    assign ctl_custom = proc_ctrl[dfc_pkg::COEFF_SEL_BIT];
    assign ctl_dec_en = proc_ctrl[dfc_pkg::DECIM_EN_BIT];
    assign ctl_rate = proc_ctrl[dfc_pkg::RATE_MSB:0];

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            use_custom_coeff_o <= 1'b0;
            offset_corr_en_o <= 1'b0;
            decim_en_o <= 1'b0;
            decim_rate_o <= dfc_pkg::RATE_DIV2;
            odd_tap_o <= 1'b0;
            filter_mode_o <= dfc_pkg::FLT_NONE;
            parallel_mode_o <= 1'b0;
            coarse_gain_o <= 1'b0;
            ext_ref_o <= 1'b0;
            lvds_sel_o <= 1'b0;
            twos_comp_o <= 1'b0;
            power_mode_o <= dfc_pkg::PWR_NORMAL;
            mux_mode_o <= 1'b0;
        end else begin
            use_custom_coeff_o <= ctl_custom;
            offset_corr_en_o <= ctl_offset;
            decim_en_o <= ctl_dec_en;
            decim_rate_o <= ctl_rate;
            odd_tap_o <= proc_ctrl[dfc_pkg::ODD_TAP_BIT];
            filter_mode_o <= decode_filter(ctl_custom, ctl_dec_en,
                                           ctl_rate, band_sel);
            parallel_mode_o <= rst_pin_s;
            // Pins are treated as logic levels, not as analog straps
            coarse_gain_o <= rst_pin_s & sclk_s;
            ext_ref_o <= rst_pin_s & ~sclk_s;
            lvds_sel_o <= rst_pin_s & sen_s;
            twos_comp_o <= rst_pin_s & ~sen_s;
            power_mode_o <= ctrl_s;
            mux_mode_o <= (ctrl_s == dfc_pkg::PWR_MUX);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    soft_reset_clear_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        wr_now && wr_addr == dfc_pkg::SW_RESET_ADDR
        && wr_data[dfc_pkg::SW_RESET_BIT]
        |=> proc_ctrl == dfc_pkg::PROC_CTRL_RESET ##1 !offset_corr_en_o
    ) else $error("soft reset did not clear control");

    pin_reset_clear_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        rst_pin_s |=> proc_ctrl == dfc_pkg::PROC_CTRL_RESET
        && band_sel == dfc_pkg::BAND_SEL_RESET
    ) else $error("reset pin did not clear registers");

    frame_abort_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        state == ST_SHIFT && sen_s |=> state == ST_IDLE
    ) else $error("enable high did not end the frame");

    ctrl_write_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        wr_now && wr_addr == dfc_pkg::PROC_CTRL_ADDR && !rst_pin_s
        |=> proc_ctrl == $past(wr_data) ##1
        offset_corr_en_o == $past(ctl_offset)
    ) else $error("control write not applied");

    custom_coeff_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        ctl_custom |=> filter_mode_o == dfc_pkg::FLT_CUSTOM
        && use_custom_coeff_o
    ) else $error("custom coefficients not selected");

    div2_band_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !ctl_custom && ctl_dec_en && ctl_rate == dfc_pkg::RATE_DIV2
        && band_sel == dfc_pkg::BAND_1
        |=> filter_mode_o == dfc_pkg::FLT_HP_FS4
    ) else $error("decimate-by-2 high pass not chosen");

    div4_band_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !ctl_custom && ctl_dec_en && ctl_rate == dfc_pkg::RATE_DIV4
        && band_sel == dfc_pkg::BAND_2
        |=> filter_mode_o == dfc_pkg::FLT_BP_5FS16
    ) else $error("decimate-by-4 band pass not chosen");

    div4_edges_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !ctl_custom && ctl_dec_en && ctl_rate == dfc_pkg::RATE_DIV4
        && band_sel == dfc_pkg::BAND_3
        |=> filter_mode_o == dfc_pkg::FLT_HP_3FS8
    ) else $error("decimate-by-4 high pass not chosen");

    decim_off_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !ctl_custom && !ctl_dec_en |=> filter_mode_o == dfc_pkg::FLT_NONE
    ) else $error("filter active with decimation off");

    parallel_gain_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        rst_pin_s && sclk_s |=> coarse_gain_o && !ext_ref_o
    ) else $error("coarse gain not taken from clock pin");

    parallel_format_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !rst_pin_s |=> !lvds_sel_o && !twos_comp_o
    ) else $error("format pins active in serial mode");

    mux_decode_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        ctrl_s == dfc_pkg::PWR_MUX |=> mux_mode_o
        && power_mode_o == dfc_pkg::PWR_MUX
    ) else $error("mux mode not decoded");

    write_seen_c: cover property (
        @(posedge clk_i) disable iff (!nrst_i) wr_now);
    custom_path_c: cover property (
        @(posedge clk_i) disable iff (!nrst_i)
        filter_mode_o == dfc_pkg::FLT_CUSTOM);
    bandpass_c: cover property (
        @(posedge clk_i) disable iff (!nrst_i)
        filter_mode_o == dfc_pkg::FLT_BP_3FS16);
    parallel_c: cover property (
        @(posedge clk_i) disable iff (!nrst_i) parallel_mode_o);

endmodule

`default_nettype wire

// ---- hdl/dfc_pkg.sv ----
// Constants and encodings for the decimation filter configuration block
package dfc_pkg;

    // ------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [3:0] LAST_BIT_IDX = 4'hF;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SW_RESET_ADDR = 8'h00;
    localparam logic [7:0] PROC_CTRL_ADDR = 8'h1B;
    localparam logic [7:0] BAND_SEL_ADDR = 8'h1D;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int SW_RESET_BIT = 1;
    localparam int OFFSET_EN_BIT = 7;
    localparam int COEFF_SEL_BIT = 5;
    localparam int DECIM_EN_BIT = 4;
    localparam int ODD_TAP_BIT = 3;
    localparam int RATE_MSB = 2;
    localparam int BAND_MSB = 1;
    localparam logic [7:0] PROC_CTRL_RESET = 8'h00;
    localparam logic [1:0] BAND_SEL_RESET = 2'h0;

    // ------------------------------------------------------------
    // Decimation rate codes
    // ------------------------------------------------------------
    localparam logic [2:0] RATE_DIV2 = 3'h0;
    localparam logic [2:0] RATE_DIV4 = 3'h1;
    localparam logic [2:0] RATE_NONE = 3'h3;
    localparam logic [2:0] RATE_DIV8 = 3'h4;

    // ------------------------------------------------------------
    // Band codes
    // ------------------------------------------------------------
    localparam logic [1:0] BAND_0 = 2'h0;
    localparam logic [1:0] BAND_1 = 2'h1;
    localparam logic [1:0] BAND_2 = 2'h2;
    localparam logic [1:0] BAND_3 = 2'h3;

    // ------------------------------------------------------------
    // Selected filter response
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FLT_NONE = 3'h0,
        FLT_LP_FS4 = 3'h1,
        FLT_HP_FS4 = 3'h2,
        FLT_LP_FS8 = 3'h3,
        FLT_BP_3FS16 = 3'h4,
        FLT_BP_5FS16 = 3'h5,
        FLT_HP_3FS8 = 3'h6,
        FLT_CUSTOM = 3'h7
    } dfc_filter_type;

    // ------------------------------------------------------------
    // Power and mux control codes
    // ------------------------------------------------------------
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_STANDBY = 2'h1;
    localparam logic [1:0] PWR_OUT_OFF = 2'h2;
    localparam logic [1:0] PWR_MUX = 2'h3;

endpackage

// ---- hdl/dfc_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module dfc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end

endmodule

`default_nettype wire

// ---- verification/dfc_host.sv ----
// Host model that drives the serial configuration pins
`timescale 1ns/1ps
`default_nettype none

module dfc_host (
    // Clock
    input wire logic clk_i,
    // Configuration pins
    output logic reset_pin_o,
    output logic sclk_o,
    output logic serial_data_in_pin_o,
    output logic sen_o
);
    // Idle levels follow the pin pulls: clock and data down, enable up
    initial begin
        reset_pin_o = 1'b0;
        sclk_o = 1'b0;
        serial_data_in_pin_o = 1'b0;
        sen_o = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic init_pulse();
        @(negedge clk_i);
        reset_pin_o = 1'b1;
        wait_clk(4);
        reset_pin_o = 1'b0;
        wait_clk(4);
    endtask

    // MSB first; fewer than 16 bits aborts the frame
    task automatic send_bits(input logic [15:0] w, input int n,
                             input int half);
        @(negedge clk_i);
        sen_o = 1'b0;
        wait_clk(half);
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b1;
            serial_data_in_pin_o = w[15-i];
            wait_clk(half);
            sclk_o = 1'b0;
            wait_clk(half);
        end
        serial_data_in_pin_o = 1'b0;
        sen_o = 1'b1;
        wait_clk(6);
    endtask

    task automatic write_band(input logic [1:0] b);
        send_bits({dfc_pkg::BAND_SEL_ADDR, 6'h00, b}, 16, 4);
    endtask

    task automatic set_parallel(input logic sclk_lvl, input logic sen_lvl);
        @(negedge clk_i);
        reset_pin_o = 1'b1;
        sclk_o = sclk_lvl;
        sen_o = sen_lvl;
        wait_clk(4);
    endtask

    // Dropping the pin leaves the registers at the reset values loaded while it was held high
    task automatic leave_parallel();
        @(negedge clk_i);
        reset_pin_o = 1'b0;
        sclk_o = 1'b0;
        sen_o = 1'b1;
        wait_clk(4);
    endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the decimation filter configuration block
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic ctrl_a = 1'b0;
    logic ctrl_b = 1'b0;
    logic rst_pin, sclk, serial_data_in_pin, serial_enable_or_format_pin;
    logic use_custom, offset_en, decim_en, odd_tap, par_mode;
    logic coarse, ext_ref, lvds, twos, mux;
    logic [2:0] rate;
    logic [1:0] pwr;
    dfc_pkg::dfc_filter_type fmode;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;

    always #20 clk_i = ~clk_i;

    dfc_host host (
        .clk_i(clk_i),
        .reset_pin_o(rst_pin),
        .sclk_o(sclk),
        .serial_data_in_pin_o(serial_data_in_pin),
        .sen_o(serial_enable_or_format_pin)
    );

    dfc_top DUT (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .reset_pin_i(rst_pin),
        .serial_clock_pin_i(sclk),
        .serial_data_in_pin_i(serial_data_in_pin),
        .serial_enable_or_format_pin_i(serial_enable_or_format_pin),
        .power_mux_control_a_i(ctrl_a),
        .power_mux_control_b_i(ctrl_b),
        .use_custom_coeff_o(use_custom),
        .offset_corr_en_o(offset_en),
        .decim_en_o(decim_en),
        .decim_rate_o(rate),
        .odd_tap_o(odd_tap),
        .filter_mode_o(fmode),
        .parallel_mode_o(par_mode),
        .coarse_gain_o(coarse),
        .ext_ref_o(ext_ref),
        .lvds_sel_o(lvds),
        .twos_comp_o(twos),
        .power_mode_o(pwr),
        .mux_mode_o(mux)
    );

    task automatic close_out();
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 4700 cycles the sequence needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 20000) begin
            err_count++;
            close_out();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic write_ctrl(input logic [7:0] d, input int half);
        host.send_bits({dfc_pkg::PROC_CTRL_ADDR, d}, 16, half);
    endtask

    function automatic logic [2:0] exp_mode(input logic [7:0] c,
                                            input logic [1:0] b);
        if (c[5]) return dfc_pkg::FLT_CUSTOM;
        if (!c[4]) return dfc_pkg::FLT_NONE;
        if (c[2:0] == dfc_pkg::RATE_DIV2) begin
            if (b == 2'h0) return dfc_pkg::FLT_LP_FS4;
            if (b == 2'h1) return dfc_pkg::FLT_HP_FS4;
            return dfc_pkg::FLT_NONE;
        end
        if (c[2:0] == dfc_pkg::RATE_DIV4) begin
            if (b == 2'h0) return dfc_pkg::FLT_LP_FS8;
            if (b == 2'h1) return dfc_pkg::FLT_BP_3FS16;
            if (b == 2'h2) return dfc_pkg::FLT_BP_5FS16;
            return dfc_pkg::FLT_HP_3FS8;
        end
        return dfc_pkg::FLT_NONE;
    endfunction

    task automatic t_reset();
        host.init_pulse();
        chk({use_custom, offset_en, decim_en, odd_tap, 1'b0, rate}, 8'h00);
        chk({5'h00, fmode}, 8'h00);
        chk({par_mode, coarse, ext_ref, lvds, twos, 3'h0}, 8'h00);
    endtask

    task automatic t_ctrl();
        logic [7:0] tbl [4] = '{8'hB4, 8'h09, 8'h13, 8'h00};
        foreach (tbl[i]) begin
            write_ctrl(tbl[i], 4);
            chk({7'h00, use_custom}, {7'h00, tbl[i][5]});
            chk({7'h00, offset_en}, {7'h00, tbl[i][7]});
            chk({7'h00, decim_en}, {7'h00, tbl[i][4]});
            chk({5'h00, rate}, {5'h00, tbl[i][2:0]});
            chk({7'h00, odd_tap}, {7'h00, tbl[i][3]});
        end
    endtask

    task automatic t_band();
        logic [7:0] c;
        logic [7:0] ov [4] = '{8'h30, 8'h01, 8'h13, 8'h14};
        for (int r = 0; r < 2; r++) begin
            for (int b = 0; b < 4; b++) begin
                c = {5'h02, r[2:0]};
                write_ctrl(c, 4);
                host.write_band(b[1:0]);
                chk({5'h00, fmode}, {5'h00, exp_mode(c, b[1:0])});
            end
        end
        foreach (ov[i]) begin
            write_ctrl(ov[i], 4);
            chk({5'h00, fmode}, {5'h00, exp_mode(ov[i], 2'h1)});
        end
    endtask

    task automatic t_abort();
        write_ctrl(8'h11, 4);
        host.write_band(2'h3);
        host.send_bits({dfc_pkg::PROC_CTRL_ADDR, 8'hB0}, 10, 4);
        chk({5'h00, fmode}, {5'h00, dfc_pkg::FLT_HP_3FS8});
        host.send_bits({8'h1C, 8'hFF}, 16, 4);
        chk({use_custom, offset_en, decim_en, odd_tap, 1'b0, rate}, 8'h21);
        write_ctrl(8'h80, 6);
        chk({7'h00, offset_en}, 8'h01);
        host.send_bits({dfc_pkg::SW_RESET_ADDR, 8'h02}, 16, 4);
        chk({use_custom, offset_en, decim_en, odd_tap, 1'b0, rate}, 8'h00);
    endtask

    task automatic t_parallel();
        write_ctrl(8'hB1, 4);
        host.set_parallel(1'b1, 1'b0);
        chk({7'h00, par_mode}, 8'h01);
        chk({6'h00, coarse, ext_ref}, 8'h02);
        chk({6'h00, lvds, twos}, 8'h01);
        chk({6'h00, use_custom, offset_en}, 8'h00);
        host.set_parallel(1'b0, 1'b1);
        chk({6'h00, coarse, ext_ref}, 8'h01);
        chk({6'h00, lvds, twos}, 8'h02);
        write_ctrl(8'h80, 4);
        chk({7'h00, offset_en}, 8'h00);
        host.leave_parallel();
        chk({par_mode, coarse, ext_ref, lvds, twos, 3'h0}, 8'h00);
        write_ctrl(8'h80, 4);
        chk({7'h00, offset_en}, 8'h01);
    endtask

    task automatic t_pins();
        for (int k = 0; k < 4; k++) begin
            @(negedge clk_i);
            ctrl_a = k[1];
            ctrl_b = k[0];
            repeat (4) @(negedge clk_i);
            chk({6'h00, pwr}, {6'h00, k[1:0]});
            chk({7'h00, mux}, {7'h00, k == 3});
        end
    endtask

    initial begin
        repeat (2) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (3) @(negedge clk_i);
        t_reset();
        t_ctrl();
        t_band();
        t_abort();
        t_parallel();
        t_pins();
        close_out();
    end
endmodule
`default_nettype wire
